// File: common/lcdcb_pkg.sv
// Package: constants for the segment display driver serial front end
package lcdcb_pkg;

  // ==========================================================
  // Slave address
  localparam logic [5:0] SLAVE_ADDR_HI  = 6'h1c;  // 0111 00x
  localparam int         SLAVE_BITS     = 8;

  // ==========================================================
  // Control byte fields
  localparam int CTRL_CONT_POS = 7;
  localparam int CTRL_RS_POS   = 6;

  // ==========================================================
  // Command opcodes
  localparam logic [3:0] OP_MODE_SET   = 4'hc;   // 1100
  localparam logic [4:0] OP_DEV_SELECT = 5'h1c;  // 11100
  localparam logic [5:0] OP_BANK_SEL   = 6'h3e;  // 111110
  localparam logic [4:0] OP_BLINK_SEL  = 5'h1e;  // 11110
  localparam int         MODE_EN_POS   = 3;
  localparam int         MODE_BIAS_POS = 2;
  localparam int         BANK_IN_POS   = 1;
  localparam int         BANK_OUT_POS  = 0;
  localparam int         BLINK_ALT_POS = 2;
  localparam logic [6:0] PTR_MAX       = 7'h3b;  // 59

  // ==========================================================
  // Drive modes
  typedef enum logic [1:0]
  {
    DRV_FOUR   = 2'b00,
    DRV_STATIC = 2'b01,
    DRV_TWO    = 2'b10,
    DRV_THREE  = 2'b11
  } lcdcb_drive_t;

  // ==========================================================
  // Blink dividers
  localparam int BLINK_DIV1 = 768;
  localparam int BLINK_DIV2 = 1536;
  localparam int BLINK_DIV3 = 3072;

  // ==========================================================
  // Reset values
  localparam logic [1:0] RST_DRIVE  = 2'b00;
  localparam logic       RST_ENABLE = 1'b0;

  // ==========================================================
  // Serial receiver states
  typedef enum logic [1:0]
  {
    RX_IDLE = 2'b00,
    RX_ADDR = 2'b01,
    RX_CTRL = 2'b10,
    RX_BODY = 2'b11
  } lcdcb_rx_t;

endpackage

// File: logic/lcdcb_top.sv
// Top: serial slave, command decoder, bank selectors and blinker
// Function
// - Four-backplane mode presents rows 0,1,2,3 repeating.
// - Three-backplane cycles rows 0-2; on the lower output bank two-backplane cycles 0-1 and static holds row 0.
// - Frame sync forces row sequence to last row of the mode.
// - Output bank switch shows row 2 static, rows 2-3 two-backplane.
// - Input bank switch writes row 2 static, rows 2-3 two-backplane.
// - Input and output bank selections are independent settings.
// - Blink divides display clock by 768, 1536, 3072; off disables.
// - Alternating-bank blink swaps displayed bank at each blink toggle.
// - Display enable clear blanks display, set restores it.
// - Slave receiver only; only the acknowledge is driven.
// - Answers address 0111 00x with bit 1 matching the strap.
// - Read requests are not answered; master sends write bit zero.
// - Mismatched address ignores transfer until next start.
// - Control byte bit 7 continue, bit 6 selects command or data.
// - Addressed devices acknowledge every command and control byte.
// - Display bytes acknowledged only when subaddress counter matches strap.
// - Display byte stored at pointer, then pointer advances; subaddress advances when pointer passes 59.
// - Decoder classifies five commands by leading bits and applies fields.
// - Mode set 1100, enable, bias, drive mode field.
// - Load pointer bit 7 clear; device select 11100 loads subaddress.
// - Bank select 111110 ignored in three- and four-backplane modes.
// - Blink select 11110; alternating only in static or two-backplane.
module lcdcb_top
  import lcdcb_pkg::*;
#(
  parameter int CLK_PER_DISP = 1
)
(
  // Clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RST,
  // Serial bus, already filtered and synchronous
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_oe,
  output logic            o_sda_out,
  // Straps and display timing
  input  wire logic       i_addr_select_pin,
  input  wire logic [2:0] i_subaddress_pin,
  input  wire logic       i_disp_tick,
  input  wire logic       i_frame_sync,
  // Display side
  output logic [1:0]      o_row_sel,
  output logic            o_row_step,
  output logic            o_display_on,
  output logic            o_bias_half,
  output logic [1:0]      o_drive_mode,
  output logic            o_ram_we,
  output logic [6:0]      o_ram_addr,
  output logic [7:0]      o_ram_data,
  output logic            o_ram_bank_hi
);

  // ==========================================================
  // Bus condition detection
  logic scl_d_reg;
  logic sda_d_reg;
  wire  start_cond = scl_d_reg & i_scl & sda_d_reg & ~i_sda;
  wire  stop_cond  = scl_d_reg & i_scl & ~sda_d_reg & i_sda;
  wire  scl_rise   = ~scl_d_reg & i_scl;
  wire  scl_fall   = scl_d_reg & ~i_scl;

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= i_scl;
      sda_d_reg <= i_sda;
    end
  end

  // ==========================================================
  // Byte receiver
  lcdcb_rx_t  rx_state_reg;
  lcdcb_rx_t  rx_state_next;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic       ack_phase_reg;
  logic       ack_drive_reg;
  logic       last_ctrl_reg;
  logic       data_mode_reg;
  logic [2:0] sub_cnt_reg;

  wire [7:0] byte_in   = {shift_reg[6:0], i_sda};
  wire       byte_done = scl_rise & ~ack_phase_reg & (bit_cnt_reg == 4'h7);
  wire       addr_hit  = (byte_in[7:2] == SLAVE_ADDR_HI)
                         & (byte_in[1] == i_addr_select_pin)
                         & ~byte_in[0];
  wire       sub_match = (sub_cnt_reg == i_subaddress_pin);

  // Which bytes earn an acknowledge; the idle state stays silent
  wire       ack_want  = (rx_state_reg == RX_ADDR) ? addr_hit :
                         (rx_state_reg == RX_CTRL) ? 1'b1 :
                         (rx_state_reg == RX_BODY) & (~data_mode_reg | sub_match);

  always_comb
  begin
    rx_state_next = rx_state_reg;
    if (byte_done)
    begin
      unique case (rx_state_reg)
        RX_IDLE: rx_state_next = RX_IDLE;
        RX_ADDR: rx_state_next = addr_hit ? RX_CTRL : RX_IDLE;
        RX_CTRL: rx_state_next = RX_BODY;
        RX_BODY: rx_state_next = last_ctrl_reg ? RX_BODY : RX_CTRL;
      endcase
    end
    if (stop_cond)
      rx_state_next = RX_IDLE;
    if (start_cond)
      rx_state_next = RX_ADDR;
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      rx_state_reg  <= RX_IDLE;
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 4'h0;
      ack_phase_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      last_ctrl_reg <= 1'b0;
      data_mode_reg <= 1'b0;
    end
    else
    begin
      rx_state_reg <= rx_state_next;
      if (start_cond | stop_cond)
      begin
        bit_cnt_reg   <= 4'h0;
        ack_phase_reg <= 1'b0;
        ack_drive_reg <= 1'b0;
        last_ctrl_reg <= 1'b0;
      end
      else if (byte_done)
      begin
        bit_cnt_reg   <= 4'h0;
        ack_phase_reg <= 1'b1;
        ack_drive_reg <= ack_want;
        if (rx_state_reg == RX_CTRL)
        begin
          last_ctrl_reg <= ~byte_in[CTRL_CONT_POS];
          data_mode_reg <= byte_in[CTRL_RS_POS];
        end
      end
      else if (scl_rise & ~ack_phase_reg)
      begin
        shift_reg   <= byte_in;
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      // Ack slot: first fall opens it, second closes it, acked or not
      else if (scl_fall & ack_phase_reg & (bit_cnt_reg == 4'h0))
        bit_cnt_reg <= 4'h1;
      else if (scl_fall & ack_phase_reg)
      begin
        bit_cnt_reg   <= 4'h0;
        ack_phase_reg <= 1'b0;
        ack_drive_reg <= 1'b0;
      end
    end
  end

  // Ack output: drive low only; nothing else ever goes onto the bus
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_sda_oe  <= 1'b0;
      o_sda_out <= 1'b0;
    end
    else
    begin
      o_sda_out <= 1'b0;
      if (start_cond | stop_cond)
        o_sda_oe <= 1'b0;
      else if (scl_fall & ack_phase_reg)
        o_sda_oe <= (bit_cnt_reg == 4'h0) & ack_drive_reg;
    end
  end

  wire body_byte = byte_done & (rx_state_reg == RX_BODY);
  wire cmd_byte  = body_byte & ~data_mode_reg;
  wire data_byte = body_byte & data_mode_reg;

  // ==========================================================
  // Command decoder and control state
  logic [1:0] drive_reg;
  logic       enable_reg;
  logic       bias_reg;
  logic [6:0] ptr_reg;
  logic       in_bank_reg;
  logic       out_bank_reg;
  logic       blink_alt_reg;
  logic [1:0] blink_rate_reg;

  wire is_mode  = cmd_byte & (byte_in[7:4] == OP_MODE_SET);
  wire is_ptr   = cmd_byte & ~byte_in[7];
  wire is_dev   = cmd_byte & (byte_in[7:3] == OP_DEV_SELECT);
  wire is_bank  = cmd_byte & (byte_in[7:2] == OP_BANK_SEL);
  wire is_blink = cmd_byte & (byte_in[7:3] == OP_BLINK_SEL);
  wire low_mux  = (drive_reg == DRV_STATIC) | (drive_reg == DRV_TWO);

  // Pointer step per display byte, stored or not, depends on drive mode
  function automatic logic [6:0] ptr_step(input logic [1:0] m);
    unique case (m)
      DRV_STATIC: ptr_step = 7'h08;
      DRV_TWO:    ptr_step = 7'h04;
      DRV_THREE:  ptr_step = 7'h03;
      DRV_FOUR:   ptr_step = 7'h02;
    endcase
  endfunction

  wire [7:0] ptr_sum  = {1'b0, ptr_reg} + {1'b0, ptr_step(drive_reg)};
  wire       ptr_wrap = ptr_sum > {1'b0, PTR_MAX};

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      drive_reg      <= RST_DRIVE;
      enable_reg     <= RST_ENABLE;
      bias_reg       <= 1'b0;
      ptr_reg        <= 7'h00;
      sub_cnt_reg    <= 3'h0;
      in_bank_reg    <= 1'b0;
      out_bank_reg   <= 1'b0;
      blink_alt_reg  <= 1'b0;
      blink_rate_reg <= 2'b00;
    end
    else
    begin
      if (is_mode)
      begin
        enable_reg <= byte_in[MODE_EN_POS];
        bias_reg   <= byte_in[MODE_BIAS_POS];
        drive_reg  <= byte_in[1:0];
      end
      if (is_ptr)
        ptr_reg <= byte_in[6:0];
      else if (data_byte)
      begin
        ptr_reg <= ptr_wrap ? 7'h00 : ptr_sum[6:0];
        if (ptr_wrap)
          sub_cnt_reg <= sub_cnt_reg + 3'h1;
      end
      if (is_dev)
        sub_cnt_reg <= byte_in[2:0];
      if (is_bank & low_mux)
      begin
        in_bank_reg  <= byte_in[BANK_IN_POS];
        out_bank_reg <= byte_in[BANK_OUT_POS];
      end
      if (is_blink)
      begin
        blink_alt_reg  <= byte_in[BLINK_ALT_POS];
        blink_rate_reg <= byte_in[1:0];
      end
    end
  end

  // ==========================================================
  // Display RAM write port
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_ram_we      <= 1'b0;
      o_ram_addr    <= 7'h00;
      o_ram_data    <= 8'h00;
      o_ram_bank_hi <= 1'b0;
    end
    else
    begin
      o_ram_we      <= data_byte & sub_match;
      o_ram_addr    <= ptr_reg;
      o_ram_data    <= byte_in;
      o_ram_bank_hi <= in_bank_reg & low_mux;
    end
  end

  // ==========================================================
  // Blinker: counts display clock ticks, toggles phase every half divider
  logic [11:0] blink_cnt_reg;
  logic        blink_phase_reg;
  logic [11:0] blink_half;
  always_comb
  begin
    unique case (blink_rate_reg)
      2'b01:   blink_half = 12'(BLINK_DIV1 / 2);
      2'b10:   blink_half = 12'(BLINK_DIV2 / 2);
      2'b11:   blink_half = 12'(BLINK_DIV3 / 2);
      default: blink_half = 12'h000;
    endcase
  end
  wire blink_on   = (blink_rate_reg != 2'b00);
  wire blink_wrap = i_disp_tick & (blink_cnt_reg >= blink_half - 12'h001);

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      blink_cnt_reg   <= 12'h000;
      blink_phase_reg <= 1'b0;
    end
    else if (~blink_on)
    begin
      blink_cnt_reg   <= 12'h000;
      blink_phase_reg <= 1'b0;
    end
    else if (blink_wrap)
    begin
      blink_cnt_reg   <= 12'h000;
      blink_phase_reg <= ~blink_phase_reg;
    end
    else if (i_disp_tick)
      blink_cnt_reg <= blink_cnt_reg + 12'h001;
  end

  // ==========================================================
  // Output bank selector: row sequencer
  logic [1:0] phase_reg;
  wire  [1:0] last_row = (drive_reg == DRV_FOUR)  ? 2'd3 :
                         (drive_reg == DRV_THREE) ? 2'd2 :
                         (drive_reg == DRV_TWO)   ? 2'd1 : 2'd0;
  wire        alt_swap = blink_alt_reg & blink_phase_reg & low_mux;
  wire        out_hi   = low_mux & (out_bank_reg ^ alt_swap);
  wire  [1:0] phase_ok = (phase_reg > last_row) ? 2'h0 : phase_reg;
  wire  [1:0] phase_nx = (phase_ok >= last_row) ? 2'h0 : phase_ok + 2'h1;
  wire  [1:0] row_now  = out_hi ? {1'b1, phase_ok[0]} : phase_ok;
  // Normal blink blanks in the off phase; alternate-bank blink does not blank in static or two-backplane modes
  wire        blank    = ~enable_reg | (blink_on & blink_phase_reg & ~alt_swap);

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      phase_reg    <= 2'd0;
      o_row_sel    <= 2'd0;
      o_row_step   <= 1'b0;
      o_display_on <= 1'b0;
      o_bias_half  <= 1'b0;
      o_drive_mode <= RST_DRIVE;
    end
    else
    begin
      if (i_frame_sync)
        phase_reg <= last_row;
      else if (i_disp_tick)
        phase_reg <= phase_nx;
      o_row_sel    <= row_now;
      o_row_step   <= i_disp_tick | i_frame_sync;
      o_display_on <= ~blank;
      o_bias_half  <= bias_reg;
      o_drive_mode <= drive_reg;
    end
  end

endmodule

// File: sim/lcdcb_checker.sv
// Checker: port-level properties of the display driver serial front end
module lcdcb_checker
  import lcdcb_pkg::*;
#(
  parameter int CLK_PER_DISP = 1
)
(
  // Clock, reset and inputs
  input wire logic       I_CLK,
  input wire logic       I_RST,
  input wire logic       i_scl,
  input wire logic       i_disp_tick,
  input wire logic       i_frame_sync,
  // Design outputs
  input wire logic       o_sda_oe,
  input wire logic       o_sda_out,
  input wire logic [1:0] o_row_sel,
  input wire logic [1:0] o_drive_mode,
  input wire logic       o_ram_we,
  input wire logic [6:0] o_ram_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // ==========================================================
  // Serial side and display RAM store port
  property p_no_data; o_sda_out == 1'b0; endproperty
  a_no_data: assert property (p_no_data) else $error("sda data not low");
  property p_ack_low; $rose(o_sda_oe) |-> !i_scl; endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack raised in scl high");
  property p_ack_hold; o_sda_oe && $rose(i_scl) |=> o_sda_oe; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
  property p_we_pulse; o_ram_we |=> !o_ram_we; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("store strobe too long");
  property p_ptr_range; o_ram_we |-> o_ram_addr <= PTR_MAX; endproperty
  a_ptr_range: assert property (p_ptr_range) else $error("store address out of range");
  // ==========================================================
  // Row sequence
  property p_four_step;
    i_disp_tick && !i_frame_sync && o_drive_mode == DRV_FOUR
      |=> ##1 o_row_sel == $past(o_row_sel) + 2'h1;
  endproperty
  a_four_step: assert property (p_four_step) else $error("row did not step");
  property p_three_wrap;
    i_disp_tick && !i_frame_sync && o_drive_mode == DRV_THREE && o_row_sel == 2'h2
      |=> ##1 o_row_sel == 2'h0;
  endproperty
  a_three_wrap: assert property (p_three_wrap) else $error("row did not wrap");
  property p_sync_row;
    i_frame_sync && (o_drive_mode == DRV_FOUR || o_drive_mode == DRV_THREE)
      |=> ##1 o_row_sel == (o_drive_mode == DRV_FOUR ? 2'h3 : 2'h2);
  endproperty
  a_sync_row: assert property (p_sync_row) else $error("sync row wrong");
  property p_static_row;
    o_drive_mode == DRV_STATIC && $past(o_drive_mode, 3) == DRV_STATIC |-> !o_row_sel[0];
  endproperty
  a_static_row: assert property (p_static_row) else $error("odd row in static");
endmodule

bind lcdcb_top lcdcb_checker #(.CLK_PER_DISP(CLK_PER_DISP)) chk_u
(
  .I_CLK(I_CLK), .I_RST(I_RST), .i_scl(i_scl), .i_disp_tick(i_disp_tick),
  .i_frame_sync(i_frame_sync), .o_sda_oe(o_sda_oe), .o_sda_out(o_sda_out),
  .o_row_sel(o_row_sel), .o_drive_mode(o_drive_mode), .o_ram_we(o_ram_we),
  .o_ram_addr(o_ram_addr)
);

// File: sim/lcdcb_i2c_master.sv
// Partner: write-only two-wire bus master with pull-up on data
module lcdcb_i2c_master
(
  // Clock and device side
  input  wire logic I_CLK,
  input  wire logic i_dev_oe,
  input  wire logic i_dev_out,
  // Bus wires
  output logic      o_scl,
  output wire logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_low;
  // Pull-up: line is high unless some party pulls it down
  assign o_sda = !(sda_low || (i_dev_oe && !i_dev_out));
  initial
  begin
    o_scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge I_CLK);
  endtask
  task automatic start();
    sda_low <= 1'b1;
    w(4);
    o_scl <= 1'b0;
  endtask
  // Ends each access with a stop condition
  task automatic stop();
    w(2);
    sda_low <= 1'b1;
    w(2);
    o_scl <= 1'b1;
    w(4);
    sda_low <= 1'b0;
    w(4);
  endtask
  // Data only changes while scl is low; line released for the ack slot
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      w(2);
      sda_low <= !b[i];
      w(2);
      o_scl <= 1'b1;
      w(4);
      o_scl <= 1'b0;
    end
    w(2);
    sda_low <= 1'b0;
    w(4);
    o_scl <= 1'b1;
    w(3);
    // Ack taken at the edge that drops scl, still inside its high phase
    ack = !o_sda;
    o_scl <= 1'b0;
  endtask
endmodule

// File: sim/lcdcb_top_tb.sv
// Testbench: addressing, commands, rows, banks, stores and blink
module lcdcb_top_tb
  import lcdcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        I_CLK, I_RST, strap, tick, sync, ack, e, b;
  logic [2:0]  sub;
  wire logic   scl, sda;
  logic        oe, sdo, step, disp_on, bias, we, bank_hi;
  logic [1:0]  row, drv;
  logic [6:0]  ram_addr;
  logic [7:0]  ram_data;
  logic [15:0] stq[$];
  int          fails, tests_run, cnt;
  lcdcb_top dut_u (.I_CLK(I_CLK), .I_RST(I_RST), .i_scl(scl), .i_sda(sda),
    .o_sda_oe(oe), .o_sda_out(sdo), .i_addr_select_pin(strap), .i_subaddress_pin(sub),
    .i_disp_tick(tick), .i_frame_sync(sync), .o_row_sel(row), .o_row_step(step),
    .o_display_on(disp_on), .o_bias_half(bias), .o_drive_mode(drv), .o_ram_we(we),
    .o_ram_addr(ram_addr), .o_ram_data(ram_data), .o_ram_bank_hi(bank_hi));
  lcdcb_i2c_master mst_u (.I_CLK(I_CLK), .i_dev_oe(oe), .i_dev_out(sdo), .o_scl(scl),
    .o_sda(sda));
  initial
  begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK)
    if (we === 1'b1) stq.push_back({bank_hi, ram_addr, ram_data});
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic put(input logic [7:0] v, input logic x);
    mst_u.wr_byte(v, ack);
    check("ack", 16'(ack), 16'(x));
  endtask
  // Write bit always zero in the address byte
  task automatic cmds(input logic [7:0] c[$]);
    mst_u.start();
    put({SLAVE_ADDR_HI, strap, 1'b0}, 1'b1);
    put(8'h00, 1'b1);
    foreach (c[i]) put(c[i], 1'b1);
    mst_u.stop();
  endtask
  task automatic data(input logic [7:0] d[$], input int n);
    mst_u.start();
    put({SLAVE_ADDR_HI, strap, 1'b0}, 1'b1);
    put(8'h40, 1'b1);
    foreach (d[i]) put(d[i], 1'(i < n));
    mst_u.stop();
  endtask
  task automatic pulse(input logic s);
    sync <= s;
    tick <= !s;
    @(posedge I_CLK);
    sync <= 1'b0;
    tick <= 1'b0;
    @(posedge I_CLK);
    check("row step", 16'(step), 16'h1);
    repeat (2) @(posedge I_CLK);
  endtask
  function automatic int nrows(input logic [1:0] m);
    return (m == DRV_FOUR) ? 4 : (m == DRV_STATIC) ? 1 : (m == DRV_TWO) ? 2 : 3;
  endfunction
  // First toggle only aligns; the second gap is the half period
  task automatic blink(input int half);
    int c;
    logic was;
    c = 0;
    for (int k = 0; k < 2; k++)
    begin
      was = disp_on;
      c = 0;
      while (disp_on === was && c < 4000)
      begin
        pulse(1'b0);
        c++;
      end
      if (c == 4000)
      begin
        fails++;
        print_verdict();
      end
    end
    check("blink", 16'(c), 16'(half));
  endtask
  logic [7:0]  adr[5] = '{8'h70, 8'h72, 8'h71, 8'h73, 8'h62};
  logic [15:0] expq[3] = '{16'h80a5, 16'h083c, 16'h3a11};
  initial
  begin
    I_RST = 1'b1;
    tick = 1'b0;
    sync = 1'b0;
    fails = 0;
    tests_run = 0;
    void'($urandom(76));
    strap <= 1'($urandom);
    sub <= 3'($urandom);
    repeat (3) @(posedge I_CLK);
    I_RST <= 1'b0;
    repeat (2) @(posedge I_CLK);
    check("reset mode", 16'(drv), 16'(RST_DRIVE));
    check("reset on", 16'(disp_on), 16'(RST_ENABLE));
    foreach (adr[i])
    begin
      e = adr[i][7:1] === {SLAVE_ADDR_HI, strap} && !adr[i][0];
      mst_u.start();
      put(adr[i], e);
      put(8'h00, e);
      mst_u.stop();
    end
    for (int m = 0; m < 4; m++)
    begin
      b = 1'($urandom);
      cmds('{{OP_MODE_SET, 1'b1, b, 2'(m)}});
      check("mode", 16'(drv), 16'(m));
      check("bias", 16'(bias), 16'(b));
      check("enable", 16'(disp_on), 16'h1);
      pulse(1'b1);
      check("sync row", 16'(row), 16'(nrows(m) - 1));
      for (int k = 1; k < 6; k++)
      begin
        pulse(1'b0);
        check("row", 16'(row), 16'((nrows(m) - 1 + k) % nrows(m)));
      end
    end
    cmds('{8'hc9, 8'hfa, {OP_DEV_SELECT, sub}, 8'h00});
    data('{8'ha5}, 1);
    cmds('{8'hf9});
    pulse(1'b1);
    check("out bank", 16'(row), 16'h2);
    data('{8'h3c}, 1);
    // Pointer 58 overflows after one byte, so the subaddress steps away
    cmds('{8'hc8, 8'hfa, {OP_DEV_SELECT, sub}, 8'h3a});
    data('{8'h11, 8'h22}, 1);
    cmds('{{OP_DEV_SELECT, sub + 3'h1}});
    data('{8'h55}, 0);
    check("stores", 16'(stq.size()), 16'h3);
    foreach (expq[i]) check("store", stq[i], expq[i]);
    // Bank select sent in four-backplane mode must have left the output bank alone
    cmds('{8'hc9});
    pulse(1'b1);
    check("bank kept", 16'(row), 16'h2);
    cmds('{8'hf5});
    cnt = 0;
    while (row === 2'h2 && cnt < 400)
    begin
      pulse(1'b0);
      cnt++;
    end
    check("alt row", 16'(row), 16'h0);
    check("alt on", 16'(disp_on), 16'h1);
    check("alt ticks", 16'(cnt), 16'(BLINK_DIV1 / 2));
    for (int r = 1; r < 4; r++)
    begin
      cmds('{{OP_BLINK_SEL, 1'b0, 2'(r)}});
      blink((BLINK_DIV1 / 2) << (r - 1));
    end
    cmds('{8'hf0, 8'hc0});
    check("blank", 16'(disp_on), 16'h0);
    cmds('{8'hc8});
    check("restore", 16'(disp_on), 16'h1);
    print_verdict();
  end
endmodule
